// file: sfsp_pkg.sv
// shared constants for the serial flash status and protection block
package sfsp_pkg;
    // command codes
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] CMD_READ          = 8'h03;
    localparam logic [7:0] CMD_FAST_READ     = 8'h0B;
    localparam logic [7:0] CMD_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] CMD_DUAL_IO_READ  = 8'hBB;
    localparam logic [7:0] CMD_PAGE_ERASE    = 8'h81;
    localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] CMD_HALF_BLK_ERS  = 8'h52;
    localparam logic [7:0] CMD_BLOCK_ERASE   = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] CMD_CHIP_ERASE_B  = 8'hC7;
    localparam logic [7:0] CMD_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] CMD_DEEP_PD       = 8'hB9;
    localparam logic [7:0] CMD_RELEASE_PD    = 8'hAB;
    localparam logic [7:0] CMD_DUAL_ID_READ  = 8'h92;
    // status byte fields
    localparam int STS_BUSY_POS  = 0;
    localparam int STS_WEL_POS   = 1;
    localparam int STS_BP_LSB    = 2;
    localparam int STS_LOCK1_POS = 5;
    localparam int STS_LOCK2_POS = 6;
    localparam int STS_SRP_POS   = 7;
    localparam logic [7:0] STS_RESET = 8'h00;
    // protected area upper bounds
    localparam logic [23:0] TOP_1M_BP1 = 24'h01DFFF;
    localparam logic [23:0] TOP_1M_BP2 = 24'h01BFFF;
    localparam logic [23:0] TOP_1M_BP3 = 24'h017FFF;
    localparam logic [23:0] TOP_1M_BP4 = 24'h00FFFF;
    localparam logic [23:0] TOP_05_BP1 = 24'h00DFFF;
    localparam logic [23:0] TOP_05_BP2 = 24'h00BFFF;
    localparam logic [23:0] TOP_05_BP3 = 24'h007FFF;
    // operation time in ref_clk cycles
    localparam int OP_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: sfsp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // data
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// file: sfsp_core.sv
// command state, status byte and write protection of a serial nor flash
// Function
// - unknown command: standby, output off until select
// - valid command: active until select rises
// - sample rising edge, shift falling edge
// - dual reads drive both lanes from bit 40; input sampled on lane zero only
// - status byte layout lock, locks, protect, latch, busy
// - busy flag high during program, erase, write
// - latch clear rejects writes, programs, erases
// - protect field written only by status write
// - chip erase only when protect field zero
// - protect field and lock bit reset zero
// - lock bit plus pin low blocks writes
// - otp lock bits set once, cleared only by reset
// - power-up returns command state to idle
// - commands must be whole bytes
// - deep power-down blocks latch, status write, program, erase until release; reads still respond
// - 1-Mbit protected area decode
// - 512-Kbit protected area decode
// - write commands rejected if ended mid-byte
// - fields shifted msb first after select
`timescale 1ns/1ps
`default_nettype none
module sfsp_core #(
    parameter bit DENSITY_1M = 1'b1,
    parameter int OP_CYCLES  = sfsp_pkg::OP_CYCLES
) (
    // system clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // serial link
    input  wire logic       link_sclk_i,
    input  wire logic       chip_sel_n_i,
    input  wire logic       write_protect_n_i,
    input  wire logic       dual_lane_zero_i,
    output var  logic       dual_lane_zero_o,
    output var  logic       dual_lane_zero_oe_o,
    input  wire logic       dual_lane_one_i,
    output var  logic       dual_lane_one_o,
    output var  logic       dual_lane_one_oe_o,
    // status view
    output var  logic [7:0] status_byte_o,
    output var  logic       active_o,
    output var  logic       deep_pd_o,
    output var  logic       array_op_o
);
    typedef enum logic [2:0] {
        SFSP_IDLE   = 3'b001,
        SFSP_ACTIVE = 3'b010,
        SFSP_STBY   = 3'b100
    } sfsp_state_e;

    // link domain: shift register, bit count, output drive
    logic [5:0]  bit_cnt_ff;
    logic [31:0] shift_ff;
    logic [7:0]  cmd_ff;
    logic [7:0]  sts_snap_ff;
    logic        out_bit_ff;
    logic        out_en_ff;
    logic        dual_ff;
    logic        frame_tgl_ff;
    logic [31:0] frame_word_ff;
    logic [5:0]  frame_bits_ff;
    sfsp_state_e state_ff;
    sfsp_state_e nxt_state;

    function automatic logic cmd_known(input logic [7:0] c);
        case (c)
            sfsp_pkg::CMD_WRITE_ENABLE, sfsp_pkg::CMD_WRITE_DISABLE, sfsp_pkg::CMD_READ_STATUS,
            sfsp_pkg::CMD_STATUS_WRITE, sfsp_pkg::CMD_READ, sfsp_pkg::CMD_FAST_READ,
            sfsp_pkg::CMD_DUAL_OUT_READ, sfsp_pkg::CMD_DUAL_IO_READ, sfsp_pkg::CMD_PAGE_ERASE,
            sfsp_pkg::CMD_SECTOR_ERASE, sfsp_pkg::CMD_HALF_BLK_ERS, sfsp_pkg::CMD_BLOCK_ERASE,
            sfsp_pkg::CMD_CHIP_ERASE_A, sfsp_pkg::CMD_CHIP_ERASE_B, sfsp_pkg::CMD_PAGE_PROGRAM,
            sfsp_pkg::CMD_DEEP_PD, sfsp_pkg::CMD_RELEASE_PD, sfsp_pkg::CMD_DUAL_ID_READ: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction

    // select high acts as the link-side reset; the link clock only runs in frames
    logic link_rst;
    assign link_rst = chip_sel_n_i | sys_rst_i;

    always_ff @(posedge link_sclk_i or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
        end else begin
            shift_ff   <= {shift_ff[30:0], dual_lane_zero_i};
            bit_cnt_ff <= (bit_cnt_ff == 6'd63) ? bit_cnt_ff : bit_cnt_ff + 6'd1;
        end
    end

    // command byte captured at the eighth rising edge
    always_ff @(posedge link_sclk_i or posedge link_rst) begin
        if (link_rst) begin
            cmd_ff <= '0;
        end else if (bit_cnt_ff == 6'd7) begin
            cmd_ff <= {shift_ff[6:0], dual_lane_zero_i};
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SFSP_IDLE: begin
                if (bit_cnt_ff == 6'd7) begin
                    nxt_state = cmd_known({shift_ff[6:0], dual_lane_zero_i}) ? SFSP_ACTIVE : SFSP_STBY;
                end
            end
            SFSP_ACTIVE: nxt_state = SFSP_ACTIVE;
            SFSP_STBY:   nxt_state = SFSP_STBY;
            default:     nxt_state = SFSP_IDLE;
        endcase
    end

    // idle at reset and whenever select is high
    always_ff @(posedge link_sclk_i or posedge link_rst) begin
        if (link_rst) begin
            state_ff <= SFSP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // status snapshot, synchronised into the link domain
    logic [7:0] sts_link;
    logic [7:0] status_ff;
    sfsp_sync #(.W(8)) u_sts_sync (
        .clk_i (link_sclk_i),
        .rst_i (sys_rst_i),
        .d_i   (status_ff),
        .q_o   (sts_link)
    );

    // dual read commands drive both lanes
    always_ff @(negedge link_sclk_i or posedge link_rst) begin
        if (link_rst) begin
            out_bit_ff  <= 1'b0;
            out_en_ff   <= 1'b0;
            dual_ff     <= 1'b0;
            sts_snap_ff <= '0;
        end else if (state_ff == SFSP_ACTIVE && cmd_ff == sfsp_pkg::CMD_READ_STATUS) begin
            out_en_ff   <= 1'b1;
            out_bit_ff  <= (bit_cnt_ff[2:0] == 3'd0) ? sts_link[7] : sts_snap_ff[7];
            sts_snap_ff <= (bit_cnt_ff[2:0] == 3'd0) ? {sts_link[6:0], 1'b0} : {sts_snap_ff[6:0], 1'b0};
        end else if (state_ff == SFSP_ACTIVE && (cmd_ff == sfsp_pkg::CMD_DUAL_OUT_READ ||
                     cmd_ff == sfsp_pkg::CMD_DUAL_IO_READ || cmd_ff == sfsp_pkg::CMD_DUAL_ID_READ)
                     && bit_cnt_ff >= 6'd40) begin
            // array data lives elsewhere; lanes carry zero pattern here
            dual_ff    <= 1'b1;
            out_en_ff  <= 1'b1;
            out_bit_ff <= 1'b0;
        end else begin
            out_en_ff  <= 1'b0;
            dual_ff    <= 1'b0;
        end
    end

    assign dual_lane_one_o     = out_bit_ff;
    assign dual_lane_one_oe_o  = out_en_ff;
    assign dual_lane_zero_o    = out_bit_ff;
    assign dual_lane_zero_oe_o = dual_ff;

    // frame record handed over at select rise by a toggle
    always_ff @(posedge chip_sel_n_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_tgl_ff  <= 1'b0;
            frame_word_ff <= '0;
            frame_bits_ff <= '0;
        end else begin
            frame_tgl_ff  <= ~frame_tgl_ff;
            frame_word_ff <= shift_ff;
            frame_bits_ff <= bit_cnt_ff;
        end
    end

    // system domain
    logic [1:0]  tgl_sync;
    logic        tgl_seen_ff;
    logic        wp_n_sync;
    logic        busy_ff;
    logic        wel_ff;
    logic        deep_pd_ff;
    logic [15:0] op_cnt_ff;
    logic        chip_sel_n_sync;

    sfsp_sync #(.W(2)) u_tgl_sync (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   ({frame_tgl_ff, write_protect_n_i}),
        .q_o   (tgl_sync)
    );
    assign wp_n_sync = tgl_sync[0];

    // record is stable for many cycles once the toggle arrives
    logic        frame_done;
    logic [7:0]  f_cmd;
    logic [23:0] f_addr;
    logic [7:0]  f_data;
    logic [2:0]  bp;
    logic [23:0] prot_top;
    logic        prot_any;
    logic        addr_prot;
    logic        whole_bytes;
    logic        hw_locked;
    logic        may_write;

    assign frame_done  = tgl_sync[1] ^ tgl_seen_ff;
    assign bp          = status_ff[sfsp_pkg::STS_BP_LSB +: 3];
    assign whole_bytes = (frame_bits_ff[2:0] == 3'd0) && (frame_bits_ff != 6'd0);
    assign f_cmd  = (frame_bits_ff == 6'd8)  ? frame_word_ff[7:0]   :
                    (frame_bits_ff == 6'd16) ? frame_word_ff[15:8]  :
                    frame_word_ff[31:24];
    assign f_data = frame_word_ff[7:0];
    assign f_addr = frame_word_ff[23:0];

    always_comb begin
        prot_any = 1'b1;
        prot_top = 24'hFFFFFF;
        if (DENSITY_1M) begin
            case (bp)
                3'b000:  prot_any = 1'b0;
                3'b001:  prot_top = sfsp_pkg::TOP_1M_BP1;
                3'b010:  prot_top = sfsp_pkg::TOP_1M_BP2;
                3'b011:  prot_top = sfsp_pkg::TOP_1M_BP3;
                3'b100:  prot_top = sfsp_pkg::TOP_1M_BP4;
                default: prot_top = 24'hFFFFFF;
            endcase
        end else begin
            case (bp)
                3'b000:  prot_any = 1'b0;
                3'b001:  prot_top = sfsp_pkg::TOP_05_BP1;
                3'b010:  prot_top = sfsp_pkg::TOP_05_BP2;
                3'b011:  prot_top = sfsp_pkg::TOP_05_BP3;
                default: prot_top = 24'hFFFFFF;
            endcase
        end
    end
    assign addr_prot = prot_any && (f_addr <= prot_top);

    assign hw_locked = status_ff[sfsp_pkg::STS_SRP_POS] && !wp_n_sync;
    assign may_write = frame_done && whole_bytes && wel_ff && !busy_ff && !deep_pd_ff;

    logic start_sw;
    logic start_erase;
    logic start_addr_op;
    assign start_sw = may_write && frame_bits_ff == 6'd16 && frame_word_ff[15:8] == sfsp_pkg::CMD_STATUS_WRITE
                      && !hw_locked;
    // chip erase only with field clear
    assign start_erase = may_write && frame_bits_ff == 6'd8 && bp == 3'b000
                         && (f_cmd == sfsp_pkg::CMD_CHIP_ERASE_A || f_cmd == sfsp_pkg::CMD_CHIP_ERASE_B);
    // protected area blocks program and erase
    assign start_addr_op = may_write && frame_bits_ff >= 6'd32 && !addr_prot &&
                           (f_cmd == sfsp_pkg::CMD_PAGE_PROGRAM || f_cmd == sfsp_pkg::CMD_SECTOR_ERASE ||
                            f_cmd == sfsp_pkg::CMD_BLOCK_ERASE || f_cmd == sfsp_pkg::CMD_HALF_BLK_ERS ||
                            f_cmd == sfsp_pkg::CMD_PAGE_ERASE);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tgl_seen_ff <= 1'b0;
        end else begin
            tgl_seen_ff <= tgl_sync[1];
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_ff   <= 1'b0;
            op_cnt_ff <= '0;
        end else if (start_sw || start_erase || start_addr_op) begin
            busy_ff   <= 1'b1;
            op_cnt_ff <= 16'(OP_CYCLES - 1);
        end else if (busy_ff) begin
            op_cnt_ff <= op_cnt_ff - 16'd1;
            busy_ff   <= (op_cnt_ff != 16'd0);
        end
    end

    // latch clears with busy; write enable sets it, write disable clears it
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wel_ff <= 1'b0;
        end else if (busy_ff && op_cnt_ff == 16'd0) begin
            wel_ff <= 1'b0;
        end else if (frame_done && whole_bytes && !deep_pd_ff && !busy_ff && frame_bits_ff == 6'd8) begin
            if (f_cmd == sfsp_pkg::CMD_WRITE_ENABLE) begin
                wel_ff <= 1'b1;
            end else if (f_cmd == sfsp_pkg::CMD_WRITE_DISABLE) begin
                wel_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            deep_pd_ff <= 1'b0;
        end else if (frame_done && frame_bits_ff >= 6'd8 && f_cmd == sfsp_pkg::CMD_RELEASE_PD) begin
            deep_pd_ff <= 1'b0;
        end else if (frame_done && whole_bytes && !busy_ff && frame_bits_ff == 6'd8
                     && f_cmd == sfsp_pkg::CMD_DEEP_PD) begin
            deep_pd_ff <= 1'b1;
        end
    end

    // status byte, locks only set by status write, cleared only by reset
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_ff <= sfsp_pkg::STS_RESET;
        end else begin
            if (start_sw) begin
                status_ff[sfsp_pkg::STS_SRP_POS]     <= f_data[sfsp_pkg::STS_SRP_POS];
                status_ff[sfsp_pkg::STS_BP_LSB +: 3] <= f_data[sfsp_pkg::STS_BP_LSB +: 3];
                status_ff[sfsp_pkg::STS_LOCK1_POS]   <= status_ff[sfsp_pkg::STS_LOCK1_POS] |
                                                        f_data[sfsp_pkg::STS_LOCK1_POS];
                status_ff[sfsp_pkg::STS_LOCK2_POS]   <= status_ff[sfsp_pkg::STS_LOCK2_POS] |
                                                        f_data[sfsp_pkg::STS_LOCK2_POS];
            end
            status_ff[sfsp_pkg::STS_BUSY_POS] <= busy_ff;
            status_ff[sfsp_pkg::STS_WEL_POS]  <= wel_ff;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_byte_o <= '0;
            deep_pd_o     <= 1'b0;
            array_op_o    <= 1'b0;
            active_o      <= 1'b0;
        end else begin
            status_byte_o <= status_ff;
            deep_pd_o     <= deep_pd_ff;
            array_op_o    <= busy_ff;
            active_o      <= !chip_sel_n_sync;
        end
    end

    sfsp_sync #(.W(1)) u_cs_sync (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   (chip_sel_n_i),
        .q_o   (chip_sel_n_sync)
    );

    chk_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $past(status_ff[sfsp_pkg::STS_LOCK1_POS]) |-> status_ff[sfsp_pkg::STS_LOCK1_POS])
        else $error("lock bit cleared");
    // no status write under hardware lock
    chk_hw_lock: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        hw_locked |-> !start_sw)
        else $error("status write under hardware lock");
    chk_wel_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !wel_ff |=> !$rose(busy_ff))
        else $error("operation started without latch");
    chk_chip_erase: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (bp != 3'b000) |-> !start_erase)
        else $error("chip erase with field set");
    chk_wel_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $fell(busy_ff) |-> !wel_ff)
        else $error("latch not cleared at end");
    chk_deep_pd: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        deep_pd_ff |-> !(start_sw || start_erase || start_addr_op))
        else $error("operation in deep power-down");
    chk_whole_byte: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (frame_bits_ff[2:0] != 3'd0) |-> !(start_sw || start_erase || start_addr_op))
        else $error("partial byte command executed");
    chk_busy_len: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(busy_ff) |-> busy_ff [*8])
        else $error("busy ended early");
endmodule
`default_nettype wire

// file: sfsp_host_model.sv
// spi host controller model: select, link clock and lane zero
`timescale 1ns/1ps
`default_nettype none
module sfsp_host_model (
    // link pins toward the device
    output var  logic sclk_o,
    output var  logic cs_n_o,
    output wire logic lane0_o,
    output wire logic lane1_o,
    // device side drives
    input  wire logic dev0_i,
    input  wire logic dev0_oe_i,
    input  wire logic dev1_i,
    input  wire logic dev1_oe_i
);
    logic hd0 = 1'b0;
    logic pat = 1'b0;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // a released lane one toggles so a stale bit is never read as valid
    always #7 pat = ~pat;
    assign lane0_o = dev0_oe_i ? dev0_i : hd0;
    assign lane1_o = dev1_oe_i ? dev1_i : pat;
    task automatic xfer(input logic [31:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        #3;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            hd0 = bits[i];
            #6;
            sclk_o = 1'b1;
            rd = {rd[6:0], lane1_o};
            #6;
            sclk_o = 1'b0;
        end
        #6;
        // clock stands still and lane zero flips outside frames
        cs_n_o = 1'b1;
        hd0 = ~hd0;
    endtask
endmodule
`default_nettype wire

// file: sfsp_core_test.sv
// self-checking bench of the status and protection core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sfsp_core_test;
    localparam int OP = 16;
    logic       ref_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       wp_n      = 1'b1;
    logic       sclk, cs_n, l0, l1, l0o, l0oe, l1o, l1oe, act, dpd, aop;
    logic [7:0] sts;
    int         error_cnt = 0;
    int         n_checks  = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    sfsp_core #(.DENSITY_1M(1'b1), .OP_CYCLES(OP)) DUT (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link_sclk_i(sclk),
        .chip_sel_n_i(cs_n), .write_protect_n_i(wp_n),
        .dual_lane_zero_i(l0), .dual_lane_zero_o(l0o), .dual_lane_zero_oe_o(l0oe),
        .dual_lane_one_i(l1), .dual_lane_one_o(l1o), .dual_lane_one_oe_o(l1oe),
        .status_byte_o(sts), .active_o(act), .deep_pd_o(dpd), .array_op_o(aop));
    sfsp_host_model host (
        .sclk_o(sclk), .cs_n_o(cs_n), .lane0_o(l0), .lane1_o(l1),
        .dev0_i(l0o), .dev0_oe_i(l0oe), .dev1_i(l1o), .dev1_oe_i(l1oe));
    task automatic finish_test;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one frame, then room for the record to cross domains
    task automatic send(input logic [31:0] b, input int n);
        logic [7:0] rd;
        host.xfer(b, n, rd);
        repeat (10) @(negedge ref_clk_i);
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (aop !== 1'b0 && k < OP + 40) begin
            @(negedge ref_clk_i);
            k++;
        end
        // a hung operation counts once; the verdict still comes at the end
        if (k >= OP + 40) begin
            error_cnt++;
        end
        repeat (4) @(negedge ref_clk_i);
    endtask
    task automatic wstat(input logic [7:0] v);
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
        send({16'h0, sfsp_pkg::CMD_STATUS_WRITE, v}, 16);
        wait_idle();
    endtask
    task automatic s_reset;
        `CHK(sts, 8'h00)
        `CHK({act, dpd, aop, l1oe}, 4'b0000)
    endtask
    task automatic s_latch;
        send({16'h0, sfsp_pkg::CMD_STATUS_WRITE, 8'h0C}, 16);
        `CHK(sts, 8'h00)
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 7);
        `CHK(sts, 8'h00)
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
        `CHK(sts, 8'h02)
        send({16'h0, sfsp_pkg::CMD_STATUS_WRITE, 8'h0C}, 12);
        `CHK(sts, 8'h02)
        send({16'h0, sfsp_pkg::CMD_STATUS_WRITE, 8'h0C}, 16);
        `CHK({aop, sts[1:0]}, 3'b111)
        wait_idle();
        `CHK(sts, 8'h0C)
    endtask
    task automatic s_chip;
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
        send({24'h0, sfsp_pkg::CMD_CHIP_ERASE_A}, 8);
        `CHK(aop, 1'b0)
        wstat(8'h00);
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
        send({24'h0, sfsp_pkg::CMD_CHIP_ERASE_B}, 8);
        `CHK(aop, 1'b1)
        wait_idle();
        `CHK(sts, 8'h00)
    endtask
    // edge of each protected area and the first free address above it, then field five protecting the top sector
    task automatic s_area;
        logic [23:0] tops [4];
        tops = '{sfsp_pkg::TOP_1M_BP1, sfsp_pkg::TOP_1M_BP2,
                 sfsp_pkg::TOP_1M_BP3, sfsp_pkg::TOP_1M_BP4};
        for (int i = 0; i < 4; i++) begin
            wstat({3'b000, 3'(i + 1), 2'b00});
            send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
            send({sfsp_pkg::CMD_SECTOR_ERASE, tops[i]}, 32);
            `CHK(aop, 1'b0)
            send({sfsp_pkg::CMD_SECTOR_ERASE, tops[i] + 24'h1}, 32);
            `CHK(aop, 1'b1)
            wait_idle();
        end
        wstat(8'h14);
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
        send({sfsp_pkg::CMD_SECTOR_ERASE, 24'h01F000}, 32);
        `CHK(aop, 1'b0)
    endtask
    task automatic s_lock;
        wstat(8'h80);
        @(negedge ref_clk_i);
        wp_n = 1'b0;
        wstat(8'h00);
        `CHK({sts[7:2], aop}, 7'h40)
        @(negedge ref_clk_i);
        wp_n = 1'b1;
        wstat(8'h00);
        `CHK(sts, 8'h00)
    endtask
    task automatic s_otp;
        logic [7:0] rd;
        wstat(8'h20);
        wstat(8'h40);
        `CHK(sts, 8'h60)
        wstat(8'h00);
        `CHK(sts, 8'h60)
        // host reads status before next command
        host.xfer({16'h0, sfsp_pkg::CMD_READ_STATUS, 8'h00}, 16, rd);
        `CHK(rd, 8'h60)
        repeat (10) @(negedge ref_clk_i);
        send({16'h0, 16'hFF00}, 16);
        `CHK({sts, l1oe}, 9'h0C0)
    endtask
    task automatic s_dpd;
        send({24'h0, sfsp_pkg::CMD_DEEP_PD}, 7);
        `CHK(dpd, 1'b0)
        send({24'h0, sfsp_pkg::CMD_DEEP_PD}, 8);
        `CHK(dpd, 1'b1)
        send({24'h0, sfsp_pkg::CMD_WRITE_ENABLE}, 8);
        `CHK(sts[1], 1'b0)
        send({24'h0, sfsp_pkg::CMD_RELEASE_PD}, 8);
        `CHK(dpd, 1'b0)
    endtask
    initial begin
        repeat (3) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        s_reset();
        s_latch();
        s_chip();
        s_area();
        s_lock();
        s_otp();
        s_dpd();
        finish_test();
    end
endmodule
`default_nettype wire
